// >>> common/spfs_pkg.sv
/*
 * Constants, register map and pin role encoding of the shared pin function select block.
 * Assumes a 32-bit AXI4-Lite register bus and six shared pins.
 */
// Functional notes
// RL1 - Each pin: input, output, alt one, alt two
// RL2 - Pins 0-3 alt one reset own partition
// RL3 - Partition reset lines both received and driven
// RL4 - Pin 0 alt two: port 16 link up
// RL5 - Pin 1 alt two: port 16 link active
// RL6 - Pin 2 alt two: port 4 link up
// RL7 - Pin 3 alt two: port 4 link active
// RL8 - Pin 4 failover edges raise event when enabled
// RL9 - Pin 4 alt two: port 0 link up
// RL10 - Pin 5 alt one: hot-plug event output
// RL11 - Pin 5 alt two: port 0 link active
// RL12 - Names ending _n are asserted low
// RL13 - Role set by software, SMBus or EEPROM
// RL14 - Output drives value; input synchronised first
// RL15 - All pins general input after reset
package spfs_pkg;
    localparam int SPFS_NPIN = 6;
    localparam int SPFS_NPART = 4;
    localparam int SPFS_NEVT = 5;
    localparam int SPFS_FUNC_W = 2 * SPFS_NPIN;
    localparam int SPFS_FO_PIN = 4;
    localparam int SPFS_HP_PIN = 5;
    localparam int SPFS_FO_STAT_BIT = 4;
    localparam int SPFS_ADDR_W = 8;

    // Pin roles, Gray ordered
    typedef enum logic [1:0] {
        SPFS_ROLE_GPI = 2'h0,
        SPFS_ROLE_GPO = 2'h1,
        SPFS_ROLE_ALT1 = 2'h3,
        SPFS_ROLE_ALT2 = 2'h2
    } spfs_role_t;

    // Register byte offsets
    localparam logic [SPFS_ADDR_W-1:0] SPFS_OFS_FUNC = 8'h00;
    localparam logic [SPFS_ADDR_W-1:0] SPFS_OFS_GPO = 8'h04;
    localparam logic [SPFS_ADDR_W-1:0] SPFS_OFS_GPI = 8'h08;
    localparam logic [SPFS_ADDR_W-1:0] SPFS_OFS_STAT = 8'h0c;
    localparam logic [SPFS_ADDR_W-1:0] SPFS_OFS_MASK = 8'h10;
    localparam logic [SPFS_ADDR_W-1:0] SPFS_OFS_PRST = 8'h14;

    // Reset values
    localparam logic [SPFS_FUNC_W-1:0] SPFS_FUNC_RST = 12'h000;
    localparam logic [SPFS_NPIN-1:0] SPFS_GPO_RST = 6'h00;
    localparam logic [SPFS_NEVT-1:0] SPFS_MASK_RST = 5'h00;

    // AXI responses
    localparam logic [1:0] SPFS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPFS_RESP_SLVERR = 2'h2;
endpackage : spfs_pkg

// >>> common/spfs_pin_if.sv
/*
 * Carrier between the control core, the input synchroniser and the pin mux.
 * Assumes all three parts run on aclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface spfs_pin_if #(parameter int N = 6);
    logic [2*N-1:0] func;
    logic [N-1:0] gpo;
    logic [N-1:0] pin_sync;
    logic [N-1:0] pin_prev;
    modport ctl (output func, output gpo, input pin_sync, input pin_prev);
    modport mux (input func, input gpo);
    modport syn (output pin_sync, output pin_prev);
endinterface : spfs_pin_if
`default_nettype wire

// >>> logic/spfs_pin_sync.sv
/*
 * Two-stage synchroniser for the shared pin inputs plus one history stage.
 * Assumes pin levels may change at any time relative to aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module spfs_pin_sync
    import spfs_pkg::*;
#(
    parameter int N = SPFS_NPIN
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pads
    input wire logic [N-1:0] pin_in,
    // Core side
    spfs_pin_if.syn pins
);
    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;
    logic [N-1:0] prev_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r; // RL14
            prev_r <= sync_r;
        end
    end

    assign pins.pin_sync = sync_r;
    assign pins.pin_prev = prev_r;
endmodule : spfs_pin_sync
`default_nettype wire

// >>> logic/spfs_pin_mux.sv
/*
 * Per pin output selection by role, registered onto the pads.
 * Assumes alternate values arrive already at pad polarity.
 */
`timescale 1ns/1ps
`default_nettype none
module spfs_pin_mux
    import spfs_pkg::*;
#(
    parameter int N = SPFS_NPIN
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Role and output values
    spfs_pin_if.mux pins,
    input wire logic [N-1:0] alt1_val,
    input wire logic [N-1:0] alt1_drv,
    input wire logic [N-1:0] alt2_val,
    // Pads
    output var logic [N-1:0] pin_out,
    output var logic [N-1:0] pin_oe_n
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            spfs_role_t role;
            logic out_nxt;
            logic oe_n_nxt;
            logic out_r;
            logic oe_n_r;
            assign role = spfs_role_t'(pins.func[2*i+1:2*i]);
            always_comb begin
                out_nxt = 1'b0;
                oe_n_nxt = 1'b1;
                case (role) // RL1
                    SPFS_ROLE_GPI: begin
                        oe_n_nxt = 1'b1;
                    end
                    SPFS_ROLE_GPO: begin
                        out_nxt = pins.gpo[i]; // RL14
                        oe_n_nxt = 1'b0;
                    end
                    SPFS_ROLE_ALT1: begin
                        out_nxt = alt1_val[i];
                        oe_n_nxt = ~alt1_drv[i]; // RL3
                    end
                    SPFS_ROLE_ALT2: begin
                        out_nxt = alt2_val[i];
                        oe_n_nxt = 1'b0;
                    end
                    default: begin
                        oe_n_nxt = 1'b1;
                    end
                endcase
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    out_r <= 1'b0;
                    oe_n_r <= 1'b1; // RL15
                end else begin
                    out_r <= out_nxt;
                    oe_n_r <= oe_n_nxt;
                end
            end
            assign pin_out[i] = out_r;
            assign pin_oe_n[i] = oe_n_r;
        end
    endgenerate
endmodule : spfs_pin_mux
`default_nettype wire

// >>> logic/spfs_top.sv
/*
 * Shared pin function select: AXI4-Lite registers, role selection from three
 * configuration sources, partition reset, failover and status pin functions.
 * Assumes internal status inputs are synchronous to aclk and active high.
 */
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module spfs_top
    import spfs_pkg::*;
#(
    parameter int N = SPFS_NPIN
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [SPFS_ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output var logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    input wire logic [SPFS_ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    // Role writes from SMBus slave and EEPROM loader
    input wire logic smb_func_we,
    input wire logic [SPFS_FUNC_W-1:0] smb_func_data,
    input wire logic eeprom_func_we,
    input wire logic [SPFS_FUNC_W-1:0] eeprom_func_data,
    // Partition reset logic
    input wire logic [SPFS_NPART-1:0] part_rst_drive,
    output var logic [SPFS_NPART-1:0] partition_reset_req,
    // Failover logic
    input wire logic failover_trigger_zero_cap_en,
    output var logic failover_trigger_zero_event,
    // Hot-plug logic
    input wire logic hotplug_event,
    // Port link state
    input wire logic port16_link_up,
    input wire logic port16_link_active,
    input wire logic port4_link_up,
    input wire logic port4_link_active,
    input wire logic port0_link_up,
    input wire logic port0_link_active,
    // Pads
    input wire logic [N-1:0] pin_in,
    output var logic [N-1:0] pin_out,
    output var logic [N-1:0] pin_oe_n,
    // Interrupt
    output var logic irq
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    spfs_pin_if #(.N(N)) pins ();

    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic aw_have_r;
    logic aw_have_nxt;
    logic w_have_r;
    logic w_have_nxt;
    logic [SPFS_ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic [SPFS_FUNC_W-1:0] func_r;
    logic [SPFS_FUNC_W-1:0] func_nxt;
    logic [N-1:0] gpo_r;
    logic [N-1:0] gpo_nxt;
    logic [SPFS_NEVT-1:0] stat_r;
    logic [SPFS_NEVT-1:0] stat_nxt;
    logic [SPFS_NEVT-1:0] mask_r;
    logic [SPFS_NEVT-1:0] mask_nxt;
    logic [SPFS_NPART-1:0] prst_r;
    logic [SPFS_NPART-1:0] prst_nxt;
    logic fo_evt_r;
    logic irq_r;

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    wire aw_fire = s_axi_awvalid & awready_r;
    wire w_fire = s_axi_wvalid & wready_r;
    wire ar_fire = s_axi_arvalid & arready_r;
    wire wr_do = aw_have_r & w_have_r & ~bvalid_r;
    wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                         {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire [31:0] wbits = w_data_r & wmask;

    assign aw_have_nxt = (aw_have_r | aw_fire) & ~wr_do;
    assign w_have_nxt = (w_have_r | w_fire) & ~wr_do;
    assign bvalid_nxt = wr_do | (bvalid_r & ~s_axi_bready);
    assign awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
    assign wready_nxt = ~w_have_nxt & ~bvalid_nxt;
    assign rvalid_nxt = ar_fire | (rvalid_r & ~s_axi_rready);
    assign arready_nxt = ~rvalid_nxt;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    wire wr_func = wr_do & (aw_addr_r == SPFS_OFS_FUNC);
    wire wr_gpo = wr_do & (aw_addr_r == SPFS_OFS_GPO);
    wire wr_stat = wr_do & (aw_addr_r == SPFS_OFS_STAT);
    wire wr_mask = wr_do & (aw_addr_r == SPFS_OFS_MASK);
    wire wr_ro = wr_do & ((aw_addr_r == SPFS_OFS_GPI) | (aw_addr_r == SPFS_OFS_PRST));
    wire wr_hit = wr_func | wr_gpo | wr_stat | wr_mask | wr_ro;
    wire [SPFS_FUNC_W-1:0] func_mask = wmask[SPFS_FUNC_W-1:0];
    wire [SPFS_FUNC_W-1:0] func_sw = (func_r & ~func_mask) | wbits[SPFS_FUNC_W-1:0];
    wire [SPFS_NEVT-1:0] w1c = wr_stat ? wbits[SPFS_NEVT-1:0] : '0;

    // EEPROM load wins over SMBus, which wins over the AXI port
    assign func_nxt = eeprom_func_we ? eeprom_func_data : // RL13
                      smb_func_we ? smb_func_data :
                      wr_func ? func_sw : func_r;
    assign gpo_nxt = wr_gpo ? wbits[N-1:0] : gpo_r;
    assign mask_nxt = wr_mask ? wbits[SPFS_NEVT-1:0] : mask_r;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    wire [31:0] rd_func = {{(32-SPFS_FUNC_W){1'b0}}, func_r};
    wire [31:0] rd_gpo = {{(32-N){1'b0}}, gpo_r};
    wire [31:0] rd_gpi = {{(32-N){1'b0}}, pins.pin_sync}; // RL14
    wire [31:0] rd_stat = {{(32-SPFS_NEVT){1'b0}}, stat_r};
    wire [31:0] rd_mask = {{(32-SPFS_NEVT){1'b0}}, mask_r};
    wire [31:0] rd_prst = {{(32-SPFS_NPART){1'b0}}, prst_r};
    wire rd_hit = (s_axi_araddr == SPFS_OFS_FUNC) | (s_axi_araddr == SPFS_OFS_GPO) |
                  (s_axi_araddr == SPFS_OFS_GPI) | (s_axi_araddr == SPFS_OFS_STAT) |
                  (s_axi_araddr == SPFS_OFS_MASK) | (s_axi_araddr == SPFS_OFS_PRST);
    wire [31:0] rd_word = (s_axi_araddr == SPFS_OFS_FUNC) ? rd_func :
                          (s_axi_araddr == SPFS_OFS_GPO) ? rd_gpo :
                          (s_axi_araddr == SPFS_OFS_GPI) ? rd_gpi :
                          (s_axi_araddr == SPFS_OFS_STAT) ? rd_stat :
                          (s_axi_araddr == SPFS_OFS_MASK) ? rd_mask :
                          (s_axi_araddr == SPFS_OFS_PRST) ? rd_prst : 32'h0000_0000;

    // ------------------------------------------------------------
    // Pin roles and alternate functions
    // ------------------------------------------------------------
    logic [N-1:0] is_alt1;
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_role
            assign is_alt1[gi] = (spfs_role_t'(func_r[2*gi+1:2*gi]) == SPFS_ROLE_ALT1); // RL1
        end
    endgenerate

    // Received partition reset: pin low while in its first alternate role
    assign prst_nxt = is_alt1[SPFS_NPART-1:0] & ~pins.pin_sync[SPFS_NPART-1:0]; // RL2 RL12
    wire [SPFS_NPART-1:0] prst_rise = prst_nxt & ~prst_r;

    // Failover trigger: either edge, only while capability enabled
    wire fo_edge = pins.pin_sync[SPFS_FO_PIN] ^ pins.pin_prev[SPFS_FO_PIN];
    wire fo_evt = is_alt1[SPFS_FO_PIN] & failover_trigger_zero_cap_en & fo_edge; // RL8

    // Partition reset lines pull low when driven, else released
    wire [N-1:0] alt1_val = {~hotplug_event, 1'b1, {SPFS_NPART{1'b0}}}; // RL10 RL12
    wire [N-1:0] alt1_drv = {1'b1, 1'b0, part_rst_drive}; // RL3
    wire [N-1:0] alt2_val = {
        ~port0_link_active, // RL11
        ~port0_link_up, // RL9
        ~port4_link_active, // RL7
        ~port4_link_up, // RL6
        ~port16_link_active, // RL5
        ~port16_link_up // RL4
    };

    // Hardware set wins over a write-one clear in the same cycle
    wire [SPFS_NEVT-1:0] stat_set = {fo_evt, prst_rise};
    assign stat_nxt = (stat_r & ~w1c) | stat_set;

    // ------------------------------------------------------------
    // Bus registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
        end else begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            bvalid_r <= bvalid_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bresp_r <= SPFS_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_do) begin
                bresp_r <= wr_hit ? SPFS_RESP_OKAY : SPFS_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= '0;
            rresp_r <= SPFS_RESP_OKAY;
        end else if (ar_fire) begin
            rdata_r <= rd_word;
            rresp_r <= rd_hit ? SPFS_RESP_OKAY : SPFS_RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            func_r <= SPFS_FUNC_RST; // RL15
            gpo_r <= SPFS_GPO_RST;
            mask_r <= SPFS_MASK_RST;
            stat_r <= '0;
            prst_r <= '0;
            fo_evt_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            func_r <= func_nxt;
            gpo_r <= gpo_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            prst_r <= prst_nxt;
            fo_evt_r <= fo_evt;
            irq_r <= |(stat_r & mask_r);
        end
    end

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    assign pins.func = func_r;
    assign pins.gpo = gpo_r;

    spfs_pin_sync #(.N(N)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(pin_in),
        .pins(pins.syn)
    );

    spfs_pin_mux #(.N(N)) u_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins(pins.mux),
        .alt1_val(alt1_val),
        .alt1_drv(alt1_drv),
        .alt2_val(alt2_val),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign partition_reset_req = prst_r; // RL2
    assign failover_trigger_zero_event = fo_evt_r; // RL8
    assign irq = irq_r;
endmodule : spfs_top
`default_nettype wire

// >>> bench/spfs_board_model.sv
/*
 * Board side of the pins: pull-ups and drivers.
 * Assumes pads change on aclk edges.
 */
`timescale 1ns/1ps
`default_nettype none
module spfs_board_model
    import spfs_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Device pads
    input wire logic [SPFS_NPIN-1:0] pin_out,
    input wire logic [SPFS_NPIN-1:0] pin_oe_n,
    // Board drivers
    input wire logic [SPFS_NPIN-1:0] brd_en,
    input wire logic [SPFS_NPIN-1:0] brd_val,
    // Resolved levels
    output var logic [SPFS_NPIN-1:0] pin_in
);
    logic flip_r = 1'b0;

    // Floating pins show a changing pattern
    always_ff @(posedge aclk) begin
        flip_r <= ~flip_r;
    end

    always_comb begin
        for (int i = 0; i < SPFS_NPIN; i++) begin
            if (i < SPFS_NPART) begin
                // Pulled-up reset lines, any party may pull low
                pin_in[i] = (pin_oe_n[i] | pin_out[i]) & (~brd_en[i] | brd_val[i]);
            end else if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (brd_en[i]) begin
                pin_in[i] = brd_val[i];
            end else begin
                pin_in[i] = flip_r;
            end
        end
    end
endmodule : spfs_board_model
`default_nettype wire

// >>> bench/spfs_top_asserts.sv
/*
 * Port checker of the pin function block.
 * Assumes binding into spfs_top.
 */
`timescale 1ns/1ps
`default_nettype none
module spfs_top_asserts
    import spfs_pkg::*;
#(
    parameter int N = SPFS_NPIN
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Functions and pads
    input wire logic [SPFS_NPART-1:0] partition_reset_req,
    input wire logic failover_trigger_zero_cap_en,
    input wire logic failover_trigger_zero_event,
    input wire logic [N-1:0] pin_in,
    input wire logic [N-1:0] pin_oe_n,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic seen_r = 1'b0;
    always_ff @(posedge aclk) begin
        seen_r <= 1'b1;
    end

    reset_idle_a: assert property (disable iff (1'b0) seen_r && !$past(aresetn) |->
        pin_oe_n == '1 && partition_reset_req == '0 && !irq && !failover_trigger_zero_event)
        else $error("outputs not idle in reset");
    part_req_a: assert property (
        (partition_reset_req & $past(pin_in[SPFS_NPART-1:0], 3)) == '0)
        else $error("request without low line");
    fo_input_a: assert property (failover_trigger_zero_event |-> pin_oe_n[4])
        else $error("event on driven pin");
    fo_gate_a: assert property (failover_trigger_zero_event |-> $past(failover_trigger_zero_cap_en))
        else $error("event while disabled");
    fo_edge_a: assert property (
        failover_trigger_zero_event |-> $past(pin_in[4], 3) != $past(pin_in[4], 4))
        else $error("event without pin change");
    write_lat_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken in response");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during data");

    cover property (failover_trigger_zero_event);
    cover property ($rose(partition_reset_req[1]));
    cover property ($rose(irq));
endmodule : spfs_top_asserts
`default_nettype wire

bind spfs_top spfs_top_asserts #(.N(N)) u_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .partition_reset_req, .failover_trigger_zero_cap_en,
    .failover_trigger_zero_event, .pin_in, .pin_oe_n, .irq);

// >>> bench/tb.sv
/*
 * Bench: bus tasks and pin role scenarios.
 * Assumes the design, board model and checker.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import spfs_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic smb_func_we = 1'b0, eeprom_func_we = 1'b0;
    logic [11:0] smb_func_data = 12'h000, eeprom_func_data = 12'h000;
    logic [3:0] part_rst_drive = 4'h0, partition_reset_req;
    logic failover_trigger_zero_cap_en = 1'b0, hotplug_event = 1'b0, failover_trigger_zero_event, irq;
    logic [5:0] link = 6'h00, brd_en = 6'h00, brd_val = 6'h00, pin_in, pin_out, pin_oe_n;
    int mismatches = 0, total_checks = 0, fo_count = 0;

    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        if (failover_trigger_zero_event === 1'b1) fo_count++;
    end

    spfs_top DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .smb_func_we,
        .smb_func_data, .eeprom_func_we, .eeprom_func_data, .part_rst_drive,
        .partition_reset_req, .failover_trigger_zero_cap_en, .failover_trigger_zero_event, .hotplug_event,
        .port16_link_up(link[0]), .port16_link_active(link[1]), .port4_link_up(link[2]),
        .port4_link_active(link[3]), .port0_link_up(link[4]), .port0_link_active(link[5]),
        .pin_in, .pin_out, .pin_oe_n, .irq);

    spfs_board_model u_board (.aclk, .pin_out, .pin_oe_n, .brd_en, .brd_val, .pin_in);

    // ------------
    // Bus and compare tasks
    // ------------
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask : tick

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask : chk

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        logic aw = 1'b0, w = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (n < 40 && !(aw && w && s_axi_bvalid === 1'b1)) begin
            @(posedge aclk);
            n++;
            aw = aw | (s_axi_awready === 1'b1);
            w = w | (s_axi_wready === 1'b1);
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 40) mismatches++;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (n < 40 && s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
            n++;
            s_axi_arvalid <= s_axi_arvalid && s_axi_arready !== 1'b1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 40) mismatches++;
    endtask : axr

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ------------
    // Scenarios
    // ------------
    initial begin
        tick(5);
        aresetn <= 1'b1;
        chk("oe_rst", 32'h3f, 32'(pin_oe_n));
        axr(SPFS_OFS_FUNC, rd, rsp);
        chk("func_rst", 32'h0, rd);
        axw(SPFS_OFS_FUNC, 32'h555, rsp);
        axw(SPFS_OFS_GPO, 32'h2a, rsp);
        tick(2);
        chk("gpo_oe", 32'h0, 32'(pin_oe_n));
        chk("gpo_val", 32'h2a, 32'(pin_out));
        axw(SPFS_OFS_FUNC, 32'h0, rsp);
        brd_en <= 6'h3f;
        brd_val <= 6'h19;
        tick(4);
        axr(SPFS_OFS_GPI, rd, rsp);
        chk("gpi", 32'h19, rd);
        axw(SPFS_OFS_FUNC, 32'haaa, rsp);
        brd_en <= 6'h00;
        for (int k = 0; k < 2; k++) begin
            link <= (k == 0) ? 6'h12 : 6'h2d;
            tick(3);
            chk("alt2_oe", 32'h0, 32'(pin_oe_n));
            chk("alt2_val", 32'(link ^ 6'h3f), 32'(pin_out));
        end
        axw(SPFS_OFS_FUNC, 32'hfff, rsp);
        tick(4);
        axw(SPFS_OFS_STAT, 32'h1f, rsp);
        part_rst_drive <= 4'h2;
        hotplug_event <= 1'b1;
        tick(6);
        chk("alt1_oe", 32'h1d, 32'(pin_oe_n));
        chk("alt1_out", 32'h0, 32'(pin_out & 6'h22));
        chk("req_own", 32'h2, 32'(partition_reset_req));
        brd_en <= 6'h04;
        hotplug_event <= 1'b0;
        tick(6);
        chk("hp_idle", 32'h20, 32'(pin_out & 6'h20));
        axr(SPFS_OFS_PRST, rd, rsp);
        chk("req_board", 32'h6, rd);
        axr(SPFS_OFS_STAT, rd, rsp);
        chk("stat_rst", 32'h6, rd & 32'hf);
        part_rst_drive <= 4'h0;
        brd_en <= 6'h10;
        axw(SPFS_OFS_MASK, 32'h10, rsp);
        tick(6);
        axw(SPFS_OFS_STAT, 32'h1f, rsp);
        fo_count = 0;
        brd_val <= 6'h00;
        tick(8);
        failover_trigger_zero_cap_en <= 1'b1;
        tick(2);
        chk("fo_gated", 32'h0, 32'(irq));
        brd_val <= 6'h10;
        tick(8);
        brd_val <= 6'h00;
        tick(8);
        chk("fo_edges", 32'h2, 32'(fo_count));
        chk("irq_on", 32'h1, 32'(irq));
        axw(SPFS_OFS_STAT, 32'h10, rsp);
        tick(3);
        chk("irq_off", 32'h0, 32'(irq));
        failover_trigger_zero_cap_en <= 1'b0;
        smb_func_we <= 1'b1;
        smb_func_data <= 12'h555;
        eeprom_func_we <= 1'b1;
        eeprom_func_data <= 12'haaa;
        tick(1);
        eeprom_func_we <= 1'b0;
        tick(1);
        smb_func_we <= 1'b0;
        axr(SPFS_OFS_FUNC, rd, rsp);
        chk("func_smb", 32'h555, rd);
        axw(8'h3c, 32'hffffffff, rsp);
        chk("bad_wr", 32'(SPFS_RESP_SLVERR), 32'(rsp));
        axr(8'h3c, rd, rsp);
        chk("bad_rd", 32'(SPFS_RESP_SLVERR), 32'(rsp));
        chk("bad_data", 32'h0, rd);
        give_verdict();
    end

    initial begin
        tick(3000);
        mismatches++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
